// ---- include/swsr_pkg.sv ----
package swsr_pkg;
    // Bit positions in the status result byte; byte and index widths
    localparam int unsigned ST_DIR_BIT = 7;
    localparam int unsigned ST_SECOND_BIT = 6;
    localparam int unsigned ST_SINGLE_BIT = 5;
    localparam int unsigned ST_SPEED_BIT = 4;
    localparam int unsigned ST_LINE_BIT = 3;
    localparam int unsigned ST_SHORT_BIT = 2;
    localparam int unsigned ST_PRESENCE_BIT = 1;
    localparam int unsigned ST_IGNORE_BIT = 0;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned IDX_W = 7;

    // Power-on values, read fill byte and increment constants
    localparam logic FLAG_RESET = 1'h0;
    localparam logic LINE_RESET = 1'h1;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    localparam logic [6:0] IDX_ZERO = 7'h00;
    localparam logic [6:0] IDX_ONE = 7'h01;
    localparam logic [7:0] CNT_ONE = 8'h01;

    // Response read sequence
    typedef enum logic [1:0] {
        RD_IDLE,
        RD_LEN,
        RD_RES,
        RD_DATA
    } swsr_rd_state_t;
endpackage

// ---- hdl/swsr_line_sync.sv ----
`timescale 1ns/1ps
// Three-stage synchroniser for the bus line; the level moves only once
// the second and third stages agree, which rejects a one-cycle glitch.
module swsr_line_sync (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic line_in,
    output logic level_out
);
    logic meta_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    // Synchroniser chain; only the second stage reads the first
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= swsr_pkg::LINE_RESET;
            s2_q <= swsr_pkg::LINE_RESET;
            s3_q <= swsr_pkg::LINE_RESET;
        end else begin
            meta_q <= line_in;
            s2_q <= meta_q;
            s3_q <= s2_q;
        end
    end

    // Accept a new level when the two later stages match
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            level_q <= swsr_pkg::LINE_RESET;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end

    assign level_out = level_q;
endmodule

// ---- hdl/swsr_status_result.sv ----
`timescale 1ns/1ps
// Functional notes
// - Status bit 7 holds triplet branch direction; resets 0; triplets only.
// - Status bit 6 holds triplet second-bit line sample; resets 0.
// - Status bit 5 holds single-bit or triplet first-bit sample; resets 0.
// - Single-bit command sending zero reports sample as 0.
// - Status bit 4 shows current speed: 0 standard, 1 overdrive.
// - Status bit 3 is a line level sample without bus traffic.
// - Line level resampled at read-address acknowledge when status selected.
// - Bus reset sets short flag when line low at short sample time.
// - Short flag clears on later bus reset without short.
// - Bus reset sets presence flag when presence pulse seen.
// - Presence flag clears on reset with no pulse or shorted line.
// - Status bit 0 echoes the presence-ignore bit of reset parameter.
// - Byte result holds all eight bits of last byte read from bus.
module swsr_status_result (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic line_in,
    input wire logic overdrive_in,
    input wire logic single_bit_strobe_in,
    input wire logic single_bit_tx_in,
    input wire logic triplet_first_strobe_in,
    input wire logic triplet_second_strobe_in,
    input wire logic triplet_dir_strobe_in,
    input wire logic triplet_dir_in,
    input wire logic short_strobe_in,
    input wire logic presence_strobe_in,
    input wire logic reset_param_load_in,
    input wire logic reset_param_ignore_in,
    input wire logic byte_bit_strobe_in,
    input wire logic byte_done_in,
    input wire logic read_ack_in,
    input wire logic status_selected_in,
    input wire logic rd_start_in,
    input wire logic rd_next_in,
    input wire logic rd_stop_in,
    input wire logic [7:0] resp_len_in,
    input wire logic [7:0] resp_result_in,
    input wire logic [7:0] resp_data_in,
    output logic [7:0] status_result_out,
    output logic [7:0] byte_result_out,
    output logic [7:0] rd_data_out,
    output logic [6:0] resp_addr_out,
    output logic rd_active_out
);
    logic line_lvl;
    logic dir_q;
    logic second_q;
    logic single_q;
    logic speed_q;
    logic line_q;
    logic short_q;
    logic presence_q;
    logic ignore_q;
    logic [7:0] shift_q;
    logic [7:0] byte_q;
    logic short_now;
    swsr_pkg::swsr_rd_state_t rd_state_q;
    logic [7:0] rd_data_q;
    logic [6:0] idx_q;
    logic [7:0] cnt_q;

    swsr_line_sync u_sync (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .line_in(line_in),
        .level_out(line_lvl)
    );

    // Triplet results; untouched by any other command
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dir_q <= swsr_pkg::FLAG_RESET;
            second_q <= swsr_pkg::FLAG_RESET;
        end else begin
            if (triplet_dir_strobe_in) begin
                dir_q <= triplet_dir_in;
            end
            if (triplet_second_strobe_in) begin
                second_q <= line_lvl;
            end
        end
    end

    // Single-bit sample; a transmitted zero is forced low so a slow
    // line release cannot report a one
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            single_q <= swsr_pkg::FLAG_RESET;
        end else if (single_bit_strobe_in) begin
            single_q <= single_bit_tx_in & line_lvl;
        end else if (triplet_first_strobe_in) begin
            single_q <= line_lvl;
        end
    end

    // Speed flag follows the timing in use; line level only on status read
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            speed_q <= swsr_pkg::FLAG_RESET;
            line_q <= swsr_pkg::LINE_RESET;
        end else begin
            speed_q <= overdrive_in;
            if (read_ack_in && status_selected_in) begin
                line_q <= line_lvl;
            end
        end
    end

    // Short is judged first so presence in the same reset sees it
    assign short_now = short_strobe_in ? ~line_lvl : short_q;

    // Reset cycle flags are rewritten by every bus reset
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            short_q <= swsr_pkg::FLAG_RESET;
            presence_q <= swsr_pkg::FLAG_RESET;
        end else begin
            if (short_strobe_in) begin
                short_q <= ~line_lvl;
            end
            if (presence_strobe_in) begin
                presence_q <= ~line_lvl & ~short_now;
            end
        end
    end

    // Echo of the ignore bit captured when the reset parameter is loaded
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ignore_q <= swsr_pkg::FLAG_RESET;
        end else if (reset_param_load_in) begin
            ignore_q <= reset_param_ignore_in;
        end
    end

    // Bits arrive least significant first; byte result moves only when
    // the whole byte is in, so a read never sees a half-shifted value
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_q <= swsr_pkg::BYTE_RESET;
            byte_q <= swsr_pkg::BYTE_RESET;
        end else begin
            if (byte_bit_strobe_in) begin
                shift_q <= {line_lvl, shift_q[7:1]};
            end
            if (byte_done_in) begin
                byte_q <= shift_q;
            end
        end
    end

    // Status byte assembly
    always_comb begin
        status_result_out = swsr_pkg::BYTE_RESET;
        status_result_out[swsr_pkg::ST_DIR_BIT] = dir_q;
        status_result_out[swsr_pkg::ST_SECOND_BIT] = second_q;
        status_result_out[swsr_pkg::ST_SINGLE_BIT] = single_q;
        status_result_out[swsr_pkg::ST_SPEED_BIT] = speed_q;
        status_result_out[swsr_pkg::ST_LINE_BIT] = line_q;
        status_result_out[swsr_pkg::ST_SHORT_BIT] = short_q;
        status_result_out[swsr_pkg::ST_PRESENCE_BIT] = presence_q;
        status_result_out[swsr_pkg::ST_IGNORE_BIT] = ignore_q;
    end
    assign byte_result_out = byte_q;

    // Response read: length, result, then data until stop; reads past the
    // advertised length return fill bytes rather than stale buffer data
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_state_q <= swsr_pkg::RD_IDLE;
            rd_data_q <= swsr_pkg::BYTE_RESET;
            idx_q <= swsr_pkg::IDX_ZERO;
            cnt_q <= swsr_pkg::BYTE_RESET;
        end else if (rd_stop_in) begin
            rd_state_q <= swsr_pkg::RD_IDLE;
            idx_q <= swsr_pkg::IDX_ZERO;
        end else if (rd_start_in) begin
            rd_state_q <= swsr_pkg::RD_LEN;
            rd_data_q <= resp_len_in;
            idx_q <= swsr_pkg::IDX_ZERO;
            cnt_q <= swsr_pkg::BYTE_RESET;
        end else if (rd_next_in) begin
            cnt_q <= cnt_q + swsr_pkg::CNT_ONE;
            case (rd_state_q)
                swsr_pkg::RD_LEN: begin
                    rd_state_q <= swsr_pkg::RD_RES;
                    rd_data_q <= resp_result_in;
                end
                swsr_pkg::RD_RES, swsr_pkg::RD_DATA: begin
                    rd_state_q <= swsr_pkg::RD_DATA;
                    idx_q <= idx_q + swsr_pkg::IDX_ONE;
                    if (cnt_q < resp_len_in) begin
                        rd_data_q <= resp_data_in;
                    end else begin
                        rd_data_q <= swsr_pkg::FILL_BYTE;
                    end
                end
                default: begin
                    rd_state_q <= swsr_pkg::RD_IDLE;
                end
            endcase
        end
    end

    assign rd_data_out = rd_data_q;
    assign resp_addr_out = idx_q;
    assign rd_active_out = (rd_state_q != swsr_pkg::RD_IDLE);

    chk_dir_update: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !triplet_dir_strobe_in |=> $stable(dir_q))
        else $error("direction bit moved without a triplet");
    chk_dir_value: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        triplet_dir_strobe_in
        |=> status_result_out[swsr_pkg::ST_DIR_BIT] == $past(triplet_dir_in))
        else $error("direction bit does not hold triplet choice");
    chk_second_sample: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        triplet_second_strobe_in |=> second_q == $past(line_lvl))
        else $error("second bit sample wrong");
    chk_single_sample: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        triplet_first_strobe_in && !single_bit_strobe_in
        |=> status_result_out[swsr_pkg::ST_SINGLE_BIT] == $past(line_lvl))
        else $error("first bit sample wrong");
    chk_zero_bit: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        single_bit_strobe_in && !single_bit_tx_in |=> !single_q)
        else $error("sent zero reported as one");
    chk_speed_flag: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        ##1 status_result_out[swsr_pkg::ST_SPEED_BIT] == $past(overdrive_in))
        else $error("speed flag does not follow timing");
    chk_line_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !(read_ack_in && status_selected_in) |=> $stable(line_q))
        else $error("line level moved without status read");
    chk_line_sample: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        read_ack_in && status_selected_in |=> line_q == $past(line_lvl))
        else $error("line level not resampled on status read");
    chk_short_set: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        short_strobe_in && !line_lvl |=> short_q)
        else $error("short not flagged");
    chk_short_clear: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        short_strobe_in && line_lvl |=> !short_q)
        else $error("short flag not cleared");
    chk_presence_set: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        presence_strobe_in && !line_lvl && !short_now |=> presence_q)
        else $error("presence not flagged");
    chk_presence_clear: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        presence_strobe_in && (line_lvl || short_now) |=> !presence_q)
        else $error("presence flag not cleared");
    chk_ignore_echo: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        reset_param_load_in ##1 (!reset_param_load_in)[*2]
        |-> status_result_out[swsr_pkg::ST_IGNORE_BIT] == $past(reset_param_ignore_in, 2))
        else $error("ignore echo wrong");
    chk_byte_value: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        byte_done_in |=> byte_result_out == $past(shift_q))
        else $error("byte result not the byte read");
endmodule

// ---- tb/swsr_slave_model.sv ----
`timescale 1ns/1ps
// Behavioural bus slaves on an open-drain line with a pull-up
module swsr_slave_model (
    input wire logic short_in,
    input wire logic pulse_in,
    input wire logic bit_in,
    output logic line_out
);
    // Any slave pulling low wins; a short holds the line low regardless of traffic
    assign line_out = !(short_in || pulse_in || !bit_in);
endmodule

// ---- tb/swsr_status_result_tb.sv ----
`timescale 1ns/1ps
module swsr_status_result_tb;
    logic core_clk_in = 1'h0;
    logic rst_n_in = 1'h0;
    logic [12:0] strb = 13'h0000;
    logic m_short = 1'h0, m_pulse = 1'h0, m_bit = 1'h1, line_w;
    logic od = 1'h0, tx = 1'h0, dir = 1'h0, ign = 1'h0, sel = 1'h0;
    logic e_dir = 1'h0, e_sec = 1'h0, e_sgl = 1'h0, e_ll = 1'h1;
    logic e_sd = 1'h0, e_pp = 1'h0, e_ig = 1'h0, act_w;
    logic [7:0] r_len = 8'h01, r_res = 8'h00, e_byte = 8'h00, st_w, byte_w, rd_w;
    logic [7:0] dbuf [0:127];
    logic [6:0] addr_w;
    int fail_count = 0;
    int tests_run = 0;

    swsr_slave_model swsr_slave_model_inst (.short_in(m_short), .pulse_in(m_pulse),
        .bit_in(m_bit), .line_out(line_w));

    swsr_status_result swsr_status_result_inst (.core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in), .line_in(line_w), .overdrive_in(od),
        .single_bit_strobe_in(strb[0]), .single_bit_tx_in(tx),
        .triplet_first_strobe_in(strb[1]), .triplet_second_strobe_in(strb[2]),
        .triplet_dir_strobe_in(strb[3]), .triplet_dir_in(dir),
        .short_strobe_in(strb[4]), .presence_strobe_in(strb[5]),
        .reset_param_load_in(strb[6]), .reset_param_ignore_in(ign),
        .byte_bit_strobe_in(strb[7]), .byte_done_in(strb[8]), .read_ack_in(strb[9]),
        .status_selected_in(sel), .rd_start_in(strb[10]), .rd_next_in(strb[11]),
        .rd_stop_in(strb[12]), .resp_len_in(r_len), .resp_result_in(r_res),
        .resp_data_in(dbuf[addr_w]), .status_result_out(st_w), .byte_result_out(byte_w),
        .rd_data_out(rd_w), .resp_addr_out(addr_w), .rd_active_out(act_w));

    // Free-running core clock, 100 MHz
    initial begin
        forever #5 core_clk_in = ~core_clk_in;
    end

    // Inputs move 1 ns after the edge so sampling never races the drivers
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask

    // One-cycle strobe, then a quiet cycle so back-to-back calls never collide
    task automatic pulse(input int i);
        strb[i] = 1'h1;
        tick(1);
        strb = 13'h0000;
        tick(1);
    endtask

    // Covers the line synchroniser latency before any sample strobe
    task automatic settle();
        tick(6);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic lvl();
        return !(m_short || m_pulse || !m_bit);
    endfunction

    function automatic logic [7:0] exp_st();
        return {e_dir, e_sec, e_sgl, od, e_ll, e_sd, e_pp, e_ig};
    endfunction

    // Result and data fill the length; anything beyond reads as filler
    function automatic logic [7:0] exp_rd(input int j);
        if (j >= int'(r_len)) return 8'hFF;
        return (j == 0) ? r_res : dbuf[j - 1];
    endfunction

    // One bus operation chosen by op, with its expected status or byte result
    task automatic do_op(input int op);
        m_short = ($urandom % 5) == 0;
        m_pulse = 1'h0;
        m_bit = 1'($urandom);
        settle();
        case (op)
            0: begin
                tx = 1'($urandom);
                pulse(0);
                e_sgl = tx & lvl();
                chk(st_w, exp_st());
            end
            1: begin
                pulse(1);
                e_sgl = lvl();
                m_bit = ~m_bit;
                settle();
                pulse(2);
                e_sec = lvl();
                dir = 1'($urandom);
                pulse(3);
                e_dir = dir;
                chk(st_w, exp_st());
            end
            2: begin
                pulse(4);
                e_sd = !lvl();
                m_pulse = 1'($urandom);
                settle();
                pulse(5);
                e_pp = !lvl() & !e_sd;
                chk(st_w, exp_st());
            end
            3: begin
                od = 1'($urandom);
                tick(2);
                chk(st_w, exp_st());
            end
            4: begin
                ign = 1'($urandom);
                pulse(6);
                e_ig = ign;
                chk(st_w, exp_st());
            end
            5: begin
                for (int b = 0; b < 8; b++) begin
                    m_bit = 1'($urandom);
                    e_byte[b] = lvl();
                    settle();
                    pulse(7);
                end
                pulse(8);
                chk(byte_w, e_byte);
            end
            default: begin
                sel = 1'($urandom);
                pulse(9);
                if (sel) e_ll = lvl();
                chk(st_w, exp_st());
            end
        endcase
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence: reset values, random flag traffic, then response reads
    initial begin
        void'($urandom(33));
        for (int k = 0; k < 128; k++) dbuf[k] = 8'($urandom);
        tick(4);
        rst_n_in = 1'h1;
        chk(st_w, 8'h08);
        chk(byte_w, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 70; i++) do_op(i < 7 ? i : int'($urandom % 7));
        $display("test status flags done");
        repeat (4) begin
            r_len = 8'($urandom % 4 + 1);
            r_res = 8'($urandom);
            pulse(11);
            chk({7'h00, act_w}, 8'h00);
            pulse(10);
            chk(rd_w, r_len);
            for (int j = 0; j <= int'(r_len); j++) begin
                pulse(11);
                chk(rd_w, exp_rd(j));
            end
            pulse(12);
            chk({addr_w, act_w}, 8'h00);
        end
        $display("test response read done");
        end_sim();
    end
endmodule
